// ---- design/rcsp_cfg.svh ----
// Constants of the array command and status port: offsets, fields, codes.
// Assumes byte addresses on a 16-bit register port with 32-bit data.
`ifndef RCSP_CFG_SVH
`define RCSP_CFG_SVH

`define RCSP_NCH          4
`define RCSP_ADDR_W       16
`define RCSP_ID_WORDS     64
`define RCSP_CT_WORDS     128
`define RCSP_SUB_DWORDS   16
`define RCSP_BEAT_BYTES   64'h0000_0000_0000_0040

// Register offsets (byte addresses)
`define RCSP_OFS_CMD      16'h0000
`define RCSP_OFS_STATUS   16'h0004
`define RCSP_OFS_IRQ_STS  16'h0008
`define RCSP_OFS_IRQ_MSK  16'h000c
`define RCSP_OFS_ADDR_LO  16'h0010
`define RCSP_OFS_ADDR_HI  16'h0014
`define RCSP_OFS_LEN_LO   16'h0018
`define RCSP_OFS_LEN_HI   16'h001c
`define RCSP_OFS_PATTERN  16'h0020
`define RCSP_OFS_PROG_LO  16'h0024
`define RCSP_OFS_PROG_HI  16'h0028
`define RCSP_OFS_CAP_LO   16'h002c
`define RCSP_OFS_CAP_HI   16'h0030
`define RCSP_OFS_LINK     16'h0040
`define RCSP_OFS_CAUSE    16'h0050
`define RCSP_OFS_SUBM     16'h0400
`define RCSP_OFS_IDEN     16'h1000
`define RCSP_OFS_CTM      16'h2000

// Region masks
`define RCSP_MSK_SMALL    16'hfff0
`define RCSP_MSK_SUBM     16'hff00
`define RCSP_MSK_MEM      16'hf000

// Status and interrupt bit positions
`define RCSP_STS_BUSY     0
`define RCSP_STS_ERR      1
`define RCSP_STS_VFY      2
`define RCSP_IRQ_DONE     0
`define RCSP_IRQ_ERR      1
`define RCSP_IRQ_VFY      2

// Command codes
`define RCSP_CODE_IDENT   3'h0
`define RCSP_CODE_SHUT    3'h1
`define RCSP_CODE_WRITE   3'h2
`define RCSP_CODE_READ    3'h3
`define RCSP_CODE_SMART   3'h4
`define RCSP_CODE_FLUSH   3'h6

`endif

// ---- design/rcsp_pkg.sv ----
// Types of the array command and status port.
// Assumes rcsp_cfg.svh is on the include path.
`include "rcsp_cfg.svh"

package rcsp_pkg;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_RUN,
        ST_DEAD
    } rcsp_state_e;

    // Everything one channel controller reports to this port
    typedef struct packed {
        logic        init_done;
        logic        link_up;
        logic [5:0]  link_info;
        logic        done;
        logic        error;
        logic [31:0] err_cause;
        logic        verify_fail;
        logic        beat;
        logic        mem_we;
        logic        mem_sel;
        logic [6:0]  mem_addr;
        logic [31:0] mem_data;
        logic [47:0] lba_count;
    } rcsp_chan_in_s;

    typedef struct packed {
        logic       req;
        logic [2:0] code;
    } rcsp_cmd_s;

    typedef struct packed {
        logic [63:0] start_address_param;
        logic [63:0] transfer_length_param;
        logic [31:0] test_pattern_select;
    } rcsp_params_s;

endpackage

// ---- design/rcsp_chan_mem.sv ----
// Per-channel identify data memory and custom result memory.
// Assumes one writer (the channel) and one combinational reader.
`timescale 1ns/100ps
`include "rcsp_cfg.svh"

module rcsp_chan_mem #(
    parameter int ID_WORDS = `RCSP_ID_WORDS,
    parameter int CT_WORDS = `RCSP_CT_WORDS
) (
    // Clock
    input  wire logic                        clock,
    // Channel write side
    input  wire logic                        wr_en,
    input  wire logic                        wr_sel,
    input  wire logic [6:0]                  wr_addr,
    input  wire logic [31:0]                 wr_data,
    // Host read side
    input  wire logic [$clog2(ID_WORDS)-1:0] id_raddr,
    input  wire logic [$clog2(CT_WORDS)-1:0] ct_raddr,
    output logic      [31:0]                 id_rdata,
    output logic      [31:0]                 ct_rdata
);

    logic [31:0] id_mem [ID_WORDS];
    logic [31:0] ct_mem [CT_WORDS];

    // Identify words land with sel low, health log words with sel high
    always_ff @(posedge clock) begin
        if (wr_en && !wr_sel) begin
            id_mem[wr_addr[$clog2(ID_WORDS)-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (wr_en && wr_sel) begin
            ct_mem[wr_addr[$clog2(CT_WORDS)-1:0]] <= wr_data;
        end
    end

    // Asynchronous read so the port still answers one cycle after a strobe
    assign id_rdata = id_mem[id_raddr];
    assign ct_rdata = ct_mem[ct_raddr];

endmodule

// ---- design/rcsp_top.sv ----
// Command and status port of a four-channel striped storage array.
// Assumes channel controllers on the same clock and a single-cycle master.
//
// Functional notes
// - Busy stays set through power-up init, then clears; host checks errors.
// - Each channel link register shows lane count and speed in bits 7:2.
// - Code 000 sends Identify to all four channels and raises busy.
// - Identify end clears busy with identify data stored per channel.
// - Model name readable from identify memory, array capacity from register.
// - Any command error sets status bit one; per-channel 32-bit cause kept.
// - Code 010 starts Write, 011 starts Read; both raise busy.
// - Read verification failure sets status bit two; transfer keeps running.
// - Running byte count readable while Write or Read is in progress.
// - Code 100 sends loaded SMART entries to all channels, raising busy.
// - SMART end clears busy with health logs in custom result memory.
// - Code 110 sends loaded Flush entries to all channels, raising busy.
// - Code 001 sends Shutdown to all four channels and raises busy.
// - After Shutdown the port goes inactive and takes no command.
`timescale 1ns/100ps
`include "rcsp_cfg.svh"

module rcsp_top
    import rcsp_pkg::*;
#(
    parameter int NCH = `RCSP_NCH
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rstn,
    // Register port
    input  wire logic [`RCSP_ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // Interrupt
    output logic                            irq,
    // Channel controllers
    input  wire rcsp_pkg::rcsp_chan_in_s [NCH-1:0] chan_in,
    output rcsp_pkg::rcsp_cmd_s             cmd_out,
    output rcsp_pkg::rcsp_params_s          params,
    output logic [NCH-1:0][`RCSP_SUB_DWORDS-1:0][31:0] sub_entry
);

    import rcsp_pkg::*;

    localparam int IDW = $clog2(`RCSP_ID_WORDS);
    localparam int CTW = $clog2(`RCSP_CT_WORDS);

    rcsp_state_e       state_q;
    logic [2:0]        code_q;
    logic [NCH-1:0]    seen_q;
    logic              err_q;
    logic              vfy_q;
    logic [31:0]       cause_q [NCH];
    logic [63:0]       progress_q;
    logic [63:0]       cap_q;
    logic [2:0]        irq_sts_q;
    logic [2:0]        irq_msk_q;
    logic [31:0]       rdata_d;
    logic [31:0]       id_rd [NCH];
    logic [31:0]       ct_rd [NCH];
    logic [NCH-1:0]    fin_now;
    logic [NCH-1:0]    ch_err;
    logic [NCH-1:0]    ch_vfy;
    logic [NCH-1:0]    ch_init;
    logic              all_fin;
    logic              code_ok;
    logic              cmd_wr;
    logic              accept;
    logic              is_rw;
    logic [63:0]       beat_sum;
    logic [47:0]       lba_min;
    logic [2:0]        irq_set;
    logic              busy;

    ////////////////////////////////////////////////////////////////////////
    // Command acceptance

    // Unused codes 101 and 111 are dropped rather than guessed at
    always_comb begin
        case (reg_wdata[2:0])
            `RCSP_CODE_IDENT, `RCSP_CODE_SHUT, `RCSP_CODE_WRITE,
            `RCSP_CODE_READ,  `RCSP_CODE_SMART, `RCSP_CODE_FLUSH: begin
                code_ok = 1'b1;
            end
            default: begin
                code_ok = 1'b0;
            end
        endcase
    end

    assign cmd_wr = reg_wr && (reg_addr == `RCSP_OFS_CMD);
    // Only an idle port takes a command; busy and dead states drop it
    assign accept = cmd_wr && code_ok && (state_q == ST_IDLE);
    assign busy   = (state_q == ST_INIT) || (state_q == ST_RUN);
    assign is_rw  = (code_q == `RCSP_CODE_WRITE) ||
                    (code_q == `RCSP_CODE_READ);

    // Per-channel event vectors
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fin_now[i] = chan_in[i].done || chan_in[i].error;
            ch_err[i]  = chan_in[i].error;
            ch_vfy[i]  = chan_in[i].verify_fail;
            ch_init[i] = chan_in[i].init_done;
        end
    end

    // A channel that errors is finished too, so busy cannot hang
    assign all_fin = &(seen_q | fin_now);

    ////////////////////////////////////////////////////////////////////////
    // Array sequencer

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_INIT;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (&ch_init) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (all_fin) begin
                        // Shutdown leaves the channels inactive for good
                        state_q <= (code_q == `RCSP_CODE_SHUT) ?
                                   ST_DEAD : ST_IDLE;
                    end
                end
                ST_DEAD: begin
                    state_q <= ST_DEAD;
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    // Command code latch and one-cycle fan-out request to all channels
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            code_q  <= 3'h0;
            cmd_out <= '0;
        end else begin
            cmd_out.req <= accept;
            if (accept) begin
                code_q       <= reg_wdata[2:0];
                cmd_out.code <= reg_wdata[2:0];
            end
        end
    end

    // Channels that have answered the running command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seen_q <= '0;
        end else if (accept) begin
            seen_q <= '0;
        end else if (state_q == ST_RUN) begin
            seen_q <= seen_q | fin_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error and verification flags

    // A new error in the cycle of a new command wins over the clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            err_q <= 1'b0;
            vfy_q <= 1'b0;
        end else begin
            err_q <= (|ch_err) || (err_q && !accept);
            vfy_q <= ((state_q == ST_RUN) && (code_q == `RCSP_CODE_READ)
                      && (|ch_vfy)) || (vfy_q && !accept);
        end
    end

    // Each channel keeps its last error cause until the next command
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_cause
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    cause_q[g] <= 32'h0;
                end else if (chan_in[g].error) begin
                    cause_q[g] <= chan_in[g].err_cause;
                end else if (accept) begin
                    cause_q[g] <= 32'h0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Progress count and capacity

    always_comb begin
        beat_sum = 64'h0;
        lba_min  = chan_in[0].lba_count;
        for (int i = 0; i < NCH; i++) begin
            if (chan_in[i].beat) begin
                beat_sum = beat_sum + `RCSP_BEAT_BYTES;
            end
            if (chan_in[i].lba_count < lba_min) begin
                lba_min = chan_in[i].lba_count;
            end
        end
    end

    // Count restarts at each Write or Read and holds after the end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            progress_q <= 64'h0;
        end else if (accept && ((reg_wdata[2:0] == `RCSP_CODE_WRITE) ||
                                (reg_wdata[2:0] == `RCSP_CODE_READ))) begin
            progress_q <= 64'h0;
        end else if ((state_q == ST_RUN) && is_rw) begin
            progress_q <= progress_q + beat_sum;
        end
    end

    // Striping limits each drive to the smallest one in the set
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cap_q <= 64'h0;
        end else if ((state_q == ST_RUN) && all_fin &&
                     (code_q == `RCSP_CODE_IDENT)) begin
            cap_q <= {16'h0, lba_min} * 64'(NCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter and submission registers

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            params <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `RCSP_OFS_ADDR_LO: params.start_address_param[31:0]   <=
                                       reg_wdata;
                `RCSP_OFS_ADDR_HI: params.start_address_param[63:32]  <=
                                       reg_wdata;
                `RCSP_OFS_LEN_LO:  params.transfer_length_param[31:0] <=
                                       reg_wdata;
                `RCSP_OFS_LEN_HI:  params.transfer_length_param[63:32]<=
                                       reg_wdata;
                `RCSP_OFS_PATTERN: params.test_pattern_select         <=
                                       reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // One 16-dword entry per channel, sent on SMART or Flush
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sub_entry <= '0;
        end else if (reg_wr && ((reg_addr & `RCSP_MSK_SUBM) ==
                                `RCSP_OFS_SUBM)) begin
            sub_entry[reg_addr[7:6]][reg_addr[5:2]] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    assign irq_set[`RCSP_IRQ_DONE] = (state_q == ST_RUN) && all_fin;
    assign irq_set[`RCSP_IRQ_ERR]  = |ch_err;
    assign irq_set[`RCSP_IRQ_VFY]  = (state_q == ST_RUN) && (|ch_vfy) &&
                                     (code_q == `RCSP_CODE_READ);

    // Write one to clear; a set in the same cycle survives
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_sts_q <= 3'h0;
        end else if (reg_wr && (reg_addr == `RCSP_OFS_IRQ_STS)) begin
            irq_sts_q <= (irq_sts_q & ~reg_wdata[2:0]) | irq_set;
        end else begin
            irq_sts_q <= irq_sts_q | irq_set;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_msk_q <= 3'h0;
        end else if (reg_wr && (reg_addr == `RCSP_OFS_IRQ_MSK)) begin
            irq_msk_q <= reg_wdata[2:0];
        end
    end

    // Registered output costs one cycle of latency behind the status bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_sts_q & irq_msk_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel memories

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_mem
            rcsp_chan_mem #(
                .ID_WORDS (`RCSP_ID_WORDS),
                .CT_WORDS (`RCSP_CT_WORDS)
            ) u_mem (
                .clock    (clock),
                .wr_en    (chan_in[g].mem_we),
                .wr_sel   (chan_in[g].mem_sel),
                .wr_addr  (chan_in[g].mem_addr),
                .wr_data  (chan_in[g].mem_data),
                .id_raddr (reg_addr[IDW+1:2]),
                .ct_raddr (reg_addr[CTW+1:2]),
                .id_rdata (id_rd[g]),
                .ct_rdata (ct_rd[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read as zero, except 0x1400-0x1fff and 0x2800-0x2fff, which alias the memories

    always_comb begin
        rdata_d = 32'h0;
        if ((reg_addr & `RCSP_MSK_MEM) == `RCSP_OFS_IDEN) begin
            rdata_d = id_rd[reg_addr[9:8]];
        end else if ((reg_addr & `RCSP_MSK_MEM) == `RCSP_OFS_CTM) begin
            rdata_d = ct_rd[reg_addr[10:9]];
        end else if ((reg_addr & `RCSP_MSK_SMALL) == `RCSP_OFS_LINK) begin
            rdata_d = {24'h0, chan_in[reg_addr[3:2]].link_info, 1'b0,
                       chan_in[reg_addr[3:2]].link_up};
        end else if ((reg_addr & `RCSP_MSK_SMALL) == `RCSP_OFS_CAUSE) begin
            rdata_d = cause_q[reg_addr[3:2]];
        end else begin
            case (reg_addr)
                `RCSP_OFS_STATUS:  rdata_d = {29'h0, vfy_q, err_q, busy};
                `RCSP_OFS_IRQ_STS: rdata_d = {29'h0, irq_sts_q};
                `RCSP_OFS_IRQ_MSK: rdata_d = {29'h0, irq_msk_q};
                `RCSP_OFS_CMD:     rdata_d = {29'h0, code_q};
                `RCSP_OFS_PROG_LO: rdata_d = progress_q[31:0];
                `RCSP_OFS_PROG_HI: rdata_d = progress_q[63:32];
                `RCSP_OFS_CAP_LO:  rdata_d = cap_q[31:0];
                `RCSP_OFS_CAP_HI:  rdata_d = cap_q[63:32];
                default:           rdata_d = 32'h0;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_cmd_taken;
        reg_wr && (reg_addr == `RCSP_OFS_CMD) && code_ok &&
        (state_q == ST_IDLE);
    endsequence

    sequence s_rw_taken;
        s_cmd_taken ##0 ((reg_wdata[2:0] == `RCSP_CODE_WRITE) ||
                         (reg_wdata[2:0] == `RCSP_CODE_READ));
    endsequence

    a_busy_raise: assert property (
        s_cmd_taken |=> busy && cmd_out.req && (cmd_out.code == $past(
            reg_wdata[2:0])) ##1 !cmd_out.req)
        else $error("command taken without busy and request");

    a_busy_clear: assert property (
        (state_q == ST_RUN) && all_fin |=> !busy)
        else $error("busy still set after all channels finished");

    a_init_busy: assert property (
        (state_q == ST_INIT) && !(&ch_init) |=> busy)
        else $error("busy dropped before channel init finished");

    a_busy_ignore: assert property (
        cmd_wr && busy |=> !cmd_out.req && $stable(code_q))
        else $error("command accepted while busy");

    a_dead_stays: assert property (
        (state_q == ST_DEAD) |=> (state_q == ST_DEAD) && !cmd_out.req)
        else $error("inactive port took a command");

    a_err_flag: assert property (
        chan_in[0].error |=> err_q &&
            (cause_q[0] == $past(chan_in[0].err_cause)))
        else $error("error flag or cause not captured");

    a_verify_flag: assert property (
        (state_q == ST_RUN) && (code_q == `RCSP_CODE_READ) && (|ch_vfy)
        && !all_fin |=> vfy_q && (state_q == ST_RUN))
        else $error("verify fail not flagged or read stopped");

    a_prog_clear: assert property (
        s_rw_taken |=> (progress_q == 64'h0))
        else $error("progress count not restarted");

    a_link_read: assert property (
        reg_rd && (reg_addr == `RCSP_OFS_LINK) |=>
            (reg_rdata[7:2] == $past(chan_in[0].link_info)))
        else $error("link status bits 7:2 wrong");

endmodule

// ---- dv/rcsp_top_tb.sv ----
// Self-checking bench of the array command and status port.
// Assumes rcsp_pkg and rcsp_cfg.svh are compiled ahead of this file.
`timescale 1ns/100ps

module rcsp_top_tb;
    import rcsp_pkg::*;
    logic                   clock, rstn, reg_wr, reg_rd, irq;
    logic [15:0]            reg_addr;
    logic [31:0]            reg_wdata, reg_rdata, d, v;
    rcsp_chan_in_s [3:0]    chan_in;
    rcsp_cmd_s              cmd_out;
    rcsp_params_s           params;
    logic [3:0][15:0][31:0] sub_entry;
    logic [63:0]            x, y;
    logic [3:0]             m;
    longint                 prog;
    int                     err_count, comparisons, cyc;

    rcsp_top rcsp_top_i (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .chan_in(chan_in),
        .cmd_out(cmd_out), .params(params), .sub_entry(sub_entry));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Single-cycle register write
    task automatic wr(logic [15:0] a, logic [31:0] val);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= val;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [15:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Event pulse on channels mk: kind 0 done, 1 error, 2 verify, 3 beat
    task automatic ev(logic [3:0] mk, int k);
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            for (int i = 0; i < 4; i++) begin
                chan_in[i].done <= mk[i] && k == 0 && p == 0;
                chan_in[i].error <= mk[i] && k == 1 && p == 0;
                chan_in[i].verify_fail <= mk[i] && k == 2 && p == 0;
                chan_in[i].beat <= mk[i] && k == 3 && p == 0;
            end
        end
    endtask

    task automatic mw(int c, logic s, logic [6:0] a, logic [31:0] val);
        @(posedge clock);
        chan_in[c].mem_we <= 1'b1;
        chan_in[c].mem_sel <= s;
        chan_in[c].mem_addr <= a;
        chan_in[c].mem_data <= val;
        @(posedge clock);
        chan_in[c].mem_we <= 1'b0;
    endtask

    // Command write; accepted ones pulse req with the code and raise busy
    task automatic cmd(logic [2:0] c, logic ok);
        wr(16'h0000, {29'h0, c});
        chk("req", ok, cmd_out.req);
        if (ok) begin
            chk("code", c, cmd_out.code);
            rd(16'h0004);
            chk("busy", 1, d[0]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(81));
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, chan_in} = '0;
        // Links come up with random link info and a random LBA count per drive
        for (int i = 0; i < 4; i++) begin
            chan_in[i].link_up = 1'b1;
            chan_in[i].link_info = 6'($urandom);
            chan_in[i].lba_count = 48'({$urandom, $urandom});
        end
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        rd(16'h0004);
        chk("init busy", 1, d);
        for (int i = 0; i < 4; i++) chan_in[i].init_done <= 1'b1;
        repeat (3) @(posedge clock);
        rd(16'h0004);
        chk("init done", 0, d);
        for (int i = 0; i < 4; i++) begin
            rd(16'(64 + 4 * i));
            chk("link", {chan_in[i].link_info, 2'b01}, d);
        end
        x = chan_in[0].lba_count;
        for (int i = 1; i < 4; i++)
            if (chan_in[i].lba_count < x) x = chan_in[i].lba_count;
        cmd(3'h0, 1'b1);
        cmd(3'h3, 1'b0);
        v = $urandom;
        mw(2, 1'b0, 7'h05, v);
        ev(4'hf, 0);
        rd(16'h0004);
        chk("ident end", 0, d);
        chk("irq masked", 0, irq);
        rd(16'h1214);
        chk("ident mem", v, d);
        rd(16'h002c);
        chk("cap lo", 32'(4 * x), d);
        rd(16'h0030);
        chk("cap hi", 32'((4 * x) >> 32), d);
        wr(16'h000c, 32'h7);
        repeat (2) @(posedge clock);
        #1;
        chk("irq set", 1, irq);
        wr(16'h0008, 32'h1);
        repeat (2) @(posedge clock);
        #1;
        chk("irq clear", 0, irq);
        x = {$urandom, $urandom};
        y = {$urandom, $urandom};
        v = $urandom;
        wr(16'h0010, x[31:0]);
        wr(16'h0014, x[63:32]);
        wr(16'h0018, y[31:0]);
        wr(16'h001c, y[63:32]);
        wr(16'h0020, v);
        chk("addr", x, params.start_address_param);
        chk("len", y, params.transfer_length_param);
        chk("pat", v, params.test_pattern_select);
        cmd(3'h2, 1'b1);
        prog = 0;
        repeat (4) begin
            m = 4'($urandom);
            prog += 64 * $countones(m);
            ev(m, 3);
        end
        ev(4'hf, 2);
        rd(16'h0004);
        chk("no vfy on write", 1, d);
        rd(16'h0024);
        chk("prog lo", 32'(prog), d);
        rd(16'h0028);
        chk("prog hi", 0, d);
        ev(4'hf, 0);
        cmd(3'h3, 1'b1);
        ev(4'h2, 2);
        rd(16'h0004);
        chk("vfy", 5, d);
        v = $urandom;
        chan_in[0].err_cause <= v;
        ev(4'h1, 1);
        rd(16'h0004);
        chk("err", 7, d);
        rd(16'h0050);
        chk("cause", v, d);
        ev(4'he, 0);
        rd(16'h0004);
        chk("read end", 6, d);
        for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 16; w++) begin
                v = $urandom;
                wr(16'(1024 + 64 * c + 4 * w), v);
                chk("sub", v, sub_entry[c][w]);
            end
        end
        cmd(3'h4, 1'b1);
        v = $urandom;
        mw(1, 1'b1, 7'h64, v);
        ev(4'hf, 0);
        rd(16'h2390);
        chk("smart mem", v, d);
        cmd(3'h5, 1'b0);
        cmd(3'h7, 1'b0);
        cmd(3'h6, 1'b1);
        ev(4'hf, 0);
        cmd(3'h1, 1'b1);
        ev(4'hf, 0);
        rd(16'h0004);
        chk("shut end", 0, d);
        cmd(3'h0, 1'b0);
        give_verdict();
    end
endmodule
